// ===== usc_pkg.sv
// Constants, field layouts and carrier types for one serial channel.
// Assumes a 40 MHz pclk and a register bus of 32-bit APB words.
package usc_pkg;
  // Clocking: pclk and the baud reference
  localparam int CLK_HZ     = 40_000_000;
  localparam int CLK_MHZ    = CLK_HZ / 1_000_000;
  localparam int OSC_MHZ    = 6;
  localparam int REF_MULT   = 8;
  localparam int REF_MHZ    = OSC_MHZ * REF_MULT;
  localparam int OVERSAMPLE = 16;
  localparam int FRAC_STEPS = 8;
  // Phase step per pclk, and bit period scale per eighth of divisor
  localparam logic [27:0] ACC_INC   = 28'(REF_MHZ * FRAC_STEPS);
  localparam logic [9:0]  BIT_SCALE = 10'(OVERSAMPLE * CLK_MHZ);
  localparam logic [14:0] DIV_N_MAX = 15'h4000;
  // Buffer timeout: step of 1 ms
  localparam int TMO_STEP_MS = 1;
  localparam int MS_CYCLES   = TMO_STEP_MS * CLK_HZ / 1000;
  localparam int MS_W        = 17;
  // Buffers
  localparam int TX_DEPTH = 128;
  localparam int RX_DEPTH = 384;
  localparam int RX_HIGH  = 352;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_BAUD  = 12'h004;
  localparam logic [11:0] OFS_TMO   = 12'h008;
  localparam logic [11:0] OFS_BBDIR = 12'h00C;
  localparam logic [11:0] OFS_MODEM = 12'h010;
  localparam logic [11:0] OFS_IRQST = 12'h014;
  localparam logic [11:0] OFS_IRQMK = 12'h018;
  localparam logic [11:0] OFS_LEVEL = 12'h01C;
  // Field positions
  localparam int CTRL_SEVEN = 2;
  localparam int CTRL_BRK   = 3;
  localparam int CTRL_RTS   = 4;
  localparam int CTRL_DTR   = 5;
  localparam int CTRL_FLOW  = 6;
  localparam int BAUD_FRAC  = 14;
  localparam int LEVEL_RX   = 16;
  // Interrupt bits
  localparam int IRQ_RXAV = 0;
  localparam int IRQ_BRK  = 1;
  localparam int IRQ_TMO  = 2;
  localparam int IRQ_FLSH = 3;
  localparam int IRQ_OVR  = 4;
  localparam int IRQ_W    = 5;
  // Reset values
  localparam logic [13:0] RST_BAUD_N = 14'h0138;
  localparam logic [2:0]  RST_BAUD_F = 3'h4;
  localparam logic [7:0]  RST_TMO    = 8'h10;
  // Software flow characters
  localparam logic [7:0] XON_CHAR  = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  typedef enum logic [1:0] {
    USC_UART = 2'b00, USC_BB_ASYNC = 2'b01, USC_BB_SYNC = 2'b10
  } usc_mode_t;
  typedef enum logic [1:0] {
    FLOW_NONE = 2'b00, FLOW_RTSCTS = 2'b01,
    FLOW_DTRDSR = 2'b10, FLOW_XONXOFF = 2'b11
  } usc_flow_t;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00, SER_START = 2'b01, SER_DATA = 2'b10, SER_STOP = 2'b11
  } usc_ser_t;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
  } usc_modem_in_t;
  typedef struct packed {
    logic rts_n;
    logic dtr_n;
  } usc_modem_out_t;
endpackage : usc_pkg

// ===== usc_channel.sv
// One serial channel: APB registers, UART with modem lines, bit-bang port,
// transmit and receive buffers and the receive release timeout.
// Assumes all pins are asynchronous to pclk; the USB side is on pclk.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Receive timeout programmable 1 to 255 ms in 1 ms steps.
// - Divisor is integer n from 1 to 16384 plus eighths.
// - Bit timing derived from 48 MHz reference, x16, 14-bit plus 3 bits.
// - Bit rate spans 183 baud up to 3 Mbaud.
// - Async bit-bang drives bytes on 8-bit port, paced by baud timer.
// - Bit-bang read and write strobes appear on pins.
// - Sync bit-bang samples port only after each byte written.
// - UART serialises and deserialises seven or eight data bits.
// - Modem lines RTS, CTS, DSR, DTR, DCD and RI provided.
// - Line driver enable high while transmitting.
// - RTS/CTS and DSR/DTR handshakes done in hardware; received XON/XOFF only pauses transmit, none are sent.
// - Break can be forced on transmit and is detected on receive.
// - 128-byte transmit buffer filled by USB, drained to transmitter.
// - 384-byte receive buffer filled by receiver, drained by USB.
// - Reference is 6 MHz oscillator times eight.
// - Without valid configuration, channel starts as serial UART.
// - Send-immediate low pulse releases all pending receive data.
module usc_channel
  import usc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // USB data-out endpoint side
  input  wire logic        tx_in_valid,
  input  wire logic [7:0]  tx_in_data,
  output logic             tx_in_ready,
  // USB data-in endpoint side
  output logic             rx_out_valid,
  output logic [7:0]       rx_out_data,
  input  wire logic        rx_out_ready,
  output logic             rx_release,
  // Configuration straps
  input  wire logic        cfg_present,
  input  wire logic        cfg_parallel,
  // UART pins
  output logic             txd,
  input  wire logic        rxd,
  input  wire usc_modem_in_t  modem_in,
  output usc_modem_out_t   modem_out,
  output logic             line_driver_enable,
  input  wire logic        flush_or_wakeup_n,
  // Bit-bang port
  input  wire logic [7:0]  bb_in,
  output logic      [7:0]  bb_out,
  output logic      [7:0]  bb_oe_n,
  output logic             bb_rd_n,
  output logic             bb_wr_n
);

  typedef struct packed {
    usc_mode_t     mode;
    logic [1:0]    cfg_cnt;
    logic          seven;
    logic          brk;
    logic          rts;
    logic          dtr;
    usc_flow_t     flow;
    logic [13:0]   baud_n;
    logic [2:0]    baud_f;
    logic [7:0]    tmo;
    logic [7:0]    bb_dir;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mk;
    logic [1:0]    rxd_s;
    logic          rxd_prev;
    usc_modem_in_t mdm_s1;
    usc_modem_in_t mdm_s2;
    logic [1:0]    fl_s;
    logic          fl_prev;
    logic [1:0]    present_s;
    logic [1:0]    parallel_s;
    logic [7:0]    d_s1;
    logic [7:0]    d_s2;
    logic [6:0]    tw;
    logic [6:0]    tr;
    logic [7:0]    tcnt;
    logic [8:0]    rw;
    logic [8:0]    rr;
    logic [8:0]    rcnt;
    usc_ser_t      tst;
    logic [7:0]    tsh;
    logic [2:0]    tbit;
    logic [27:0]   tacc;
    logic          txd;
    usc_ser_t      rst;
    logic [7:0]    rsh;
    logic [2:0]    rbit;
    logic [27:0]   racc;
    logic          xoff;
    logic          bb_pend;
    logic [7:0]    bb_out;
    logic          rd_n;
    logic          wr_n;
    logic [MS_W-1:0] ms_cnt;
    logic [7:0]    tmo_cnt;
    logic          release_rx;
  } usc_state_t;

  usc_state_t s;
  usc_state_t next_s;
  logic [7:0] tx_mem [TX_DEPTH];
  logic [7:0] rx_mem [RX_DEPTH];
  logic       tx_push;
  logic       tx_pop;
  logic       rx_push;
  logic [7:0] rx_push_data;
  logic       rx_pop;

  // Phase accumulator step; returns tick in the top bit
  function automatic logic [28:0] acc_step(input logic [27:0] a,
                                           input logic [27:0] t);
    logic [27:0] sum;
    sum = a + ACC_INC;
    if (sum >= t) begin
      acc_step = {1'b1, 28'(sum - t)};
    end else begin
      acc_step = {1'b0, sum};
    end
  endfunction : acc_step

  function automatic logic [8:0] rx_inc(input logic [8:0] p);
    rx_inc = (p == 9'(RX_DEPTH - 1)) ? 9'h000 : 9'(p + 9'h001);
  endfunction : rx_inc

  logic [14:0] n_eff;
  logic [27:0] bit_thr;
  logic [28:0] tstep;
  logic [28:0] rstep;
  logic        wr_acc;
  logic        flow_ok;
  logic [2:0]  last_bit;
  logic [7:0]  rx_byte;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic        ms_tick;
  logic        bb_mode;
  logic [7:0]  tmo_lim;

  always_comb begin
    next_s       = s;
    tx_pop       = 1'b0;
    rx_push      = 1'b0;
    rx_push_data = 8'h00;
    ev           = '0;
    clr          = '0;
    rx_byte      = 8'h00;
    bb_mode      = (s.mode != USC_UART);
    // Synchronisers: only the second stage is read by logic
    next_s.rxd_s      = {s.rxd_s[0], rxd};
    next_s.rxd_prev   = s.rxd_s[1];
    next_s.mdm_s1     = modem_in;
    next_s.mdm_s2     = s.mdm_s1;
    next_s.fl_s       = {s.fl_s[0], flush_or_wakeup_n};
    next_s.fl_prev    = s.fl_s[1];
    next_s.present_s  = {s.present_s[0], cfg_present};
    next_s.parallel_s = {s.parallel_s[0], cfg_parallel};
    next_s.d_s1       = bb_in;
    next_s.d_s2       = s.d_s1;
    next_s.rd_n       = 1'b1;
    next_s.wr_n       = 1'b1;

    // Straps are taken once both synchroniser stages are filled
    if (s.cfg_cnt != 2'h3) begin
      next_s.cfg_cnt = 2'(s.cfg_cnt + 2'h1);
      if (s.cfg_cnt == 2'h2) begin
        next_s.mode = (s.present_s[1] && s.parallel_s[1]) ?
                      USC_BB_ASYNC : USC_UART;
      end
    end

    // Bit period in pclk = 16 * 40 * div / 48, div in eighths
    n_eff   = (s.baud_n == 14'h0000) ? DIV_N_MAX : {1'b0, s.baud_n};
    bit_thr = 28'(BIT_SCALE * {n_eff, s.baud_f});
    tstep   = acc_step(s.tacc, bit_thr);
    rstep   = acc_step(s.racc, bit_thr);
    next_s.tacc = tstep[27:0];
    next_s.racc = rstep[27:0];
    last_bit    = s.seven ? 3'h6 : 3'h7;

    unique case (s.flow)
      FLOW_RTSCTS:  flow_ok = !s.mdm_s2.cts_n;
      FLOW_DTRDSR:  flow_ok = !s.mdm_s2.dsr_n;
      FLOW_XONXOFF: flow_ok = !s.xoff;
      FLOW_NONE:    flow_ok = 1'b1;
    endcase

    // Transmitter
    unique case (s.tst)
      SER_IDLE: begin
        next_s.txd = 1'b1;
        if (!bb_mode && s.tcnt != 8'h00 && flow_ok && !s.brk) begin
          tx_pop      = 1'b1;
          next_s.tsh  = tx_mem[s.tr];
          next_s.txd  = 1'b0;
          next_s.tacc = 28'h0000000;
          next_s.tst  = SER_START;
        end
      end
      SER_START: begin
        if (tstep[28]) begin
          next_s.txd  = s.tsh[0];
          next_s.tsh  = {1'b0, s.tsh[7:1]};
          next_s.tbit = 3'h0;
          next_s.tst  = SER_DATA;
        end
      end
      SER_DATA: begin
        if (tstep[28]) begin
          if (s.tbit == last_bit) begin
            next_s.txd = 1'b1;
            next_s.tst = SER_STOP;
          end else begin
            next_s.txd  = s.tsh[0];
            next_s.tsh  = {1'b0, s.tsh[7:1]};
            next_s.tbit = 3'(s.tbit + 3'h1);
          end
        end
      end
      SER_STOP: begin
        if (tstep[28]) begin
          next_s.tst = SER_IDLE;
        end
      end
    endcase

    // Receiver: start edge arms a half-bit phase for mid-bit sampling
    unique case (s.rst)
      SER_IDLE: begin
        if (!bb_mode && s.rxd_prev && !s.rxd_s[1]) begin
          next_s.racc = {1'b0, bit_thr[27:1]};
          next_s.rst  = SER_START;
        end
      end
      SER_START: begin
        if (rstep[28]) begin
          next_s.rbit = 3'h0;
          next_s.rst  = s.rxd_s[1] ? SER_IDLE : SER_DATA;
        end
      end
      SER_DATA: begin
        if (rstep[28]) begin
          next_s.rsh  = {s.rxd_s[1], s.rsh[7:1]};
          next_s.rbit = 3'(s.rbit + 3'h1);
          if (s.rbit == last_bit) begin
            next_s.rst = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (rstep[28]) begin
          next_s.rst = SER_IDLE;
          rx_byte    = s.seven ? {1'b0, s.rsh[7:1]} : s.rsh;
          if (!s.rxd_s[1]) begin
            // Framing errors are dropped; an all-zero frame is a break
            ev[IRQ_BRK] = (s.rsh == 8'h00);
          end else if (s.flow == FLOW_XONXOFF && rx_byte == XOFF_CHAR) begin
            next_s.xoff = 1'b1;
          end else if (s.flow == FLOW_XONXOFF && rx_byte == XON_CHAR) begin
            next_s.xoff = 1'b0;
          end else begin
            rx_push      = 1'b1;
            rx_push_data = rx_byte;
          end
        end
      end
    endcase

    // Bit-bang port paced by the transmit bit timer
    if (bb_mode && tstep[28]) begin
      if (s.mode == USC_BB_ASYNC || s.bb_pend) begin
        rx_push        = 1'b1;
        rx_push_data   = s.d_s2;
        next_s.rd_n    = 1'b0;
        next_s.bb_pend = 1'b0;
      end
      if (s.tcnt != 8'h00) begin
        tx_pop         = 1'b1;
        next_s.bb_out  = tx_mem[s.tr];
        next_s.wr_n    = 1'b0;
        next_s.bb_pend = (s.mode == USC_BB_SYNC);
      end
    end

    // Buffers
    if (rx_push && s.rcnt == 9'(RX_DEPTH)) begin
      rx_push     = 1'b0;
      ev[IRQ_OVR] = 1'b1;
    end
    ev[IRQ_RXAV] = rx_push;
    tx_push      = tx_in_valid && (s.tcnt != 8'(TX_DEPTH));
    rx_pop       = rx_out_ready && (s.rcnt != 9'h000);
    next_s.tw    = tx_push ? 7'(s.tw + 7'h01) : s.tw;
    next_s.tr    = tx_pop ? 7'(s.tr + 7'h01) : s.tr;
    next_s.tcnt  = 8'(s.tcnt + {7'h00, tx_push} - {7'h00, tx_pop});
    next_s.rw    = rx_push ? rx_inc(s.rw) : s.rw;
    next_s.rr    = rx_pop ? rx_inc(s.rr) : s.rr;
    next_s.rcnt  = 9'(s.rcnt + {8'h00, rx_push} - {8'h00, rx_pop});

    // Release timeout counted from the last received byte
    ms_tick       = (s.ms_cnt == MS_W'(MS_CYC - 1));
    next_s.ms_cnt = ms_tick ? '0 : MS_W'(s.ms_cnt + 1'b1);
    tmo_lim       = (s.tmo == 8'h00) ? 8'h01 : s.tmo;
    if (next_s.rcnt == 9'h000) begin
      next_s.release_rx = 1'b0;
    end
    if (rx_push) begin
      next_s.tmo_cnt = 8'h00;
    end else if (ms_tick && s.rcnt != 9'h000 && !s.release_rx) begin
      next_s.tmo_cnt = 8'(s.tmo_cnt + 8'h01);
      if (8'(s.tmo_cnt + 8'h01) >= tmo_lim) begin
        next_s.release_rx = 1'b1;
        ev[IRQ_TMO]       = 1'b1;
      end
    end
    if (s.fl_prev && !s.fl_s[1]) begin
      ev[IRQ_FLSH]      = 1'b1;
      next_s.release_rx = 1'b1;
    end

    // Register writes
    wr_acc = psel && penable && pwrite;
    if (wr_acc) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_s.mode  = usc_mode_t'(pwdata[1:0]);
          next_s.seven = pwdata[CTRL_SEVEN];
          next_s.brk   = pwdata[CTRL_BRK];
          next_s.rts   = pwdata[CTRL_RTS];
          next_s.dtr   = pwdata[CTRL_DTR];
          next_s.flow  = usc_flow_t'(pwdata[CTRL_FLOW +: 2]);
        end
        OFS_BAUD: begin
          next_s.baud_n = pwdata[13:0];
          next_s.baud_f = pwdata[BAUD_FRAC +: 3];
        end
        OFS_TMO:   next_s.tmo    = pwdata[7:0];
        OFS_BBDIR: next_s.bb_dir = pwdata[7:0];
        OFS_IRQST: clr           = pwdata[IRQ_W-1:0];
        OFS_IRQMK: next_s.irq_mk = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // New events win over a clear in the same cycle
    next_s.irq_st = (s.irq_st & ~clr) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.mode       <= USC_UART;
      s.flow       <= FLOW_NONE;
      s.baud_n     <= RST_BAUD_N;
      s.baud_f     <= RST_BAUD_F;
      s.tmo        <= RST_TMO;
      s.rxd_s      <= 2'h3;
      s.rxd_prev   <= 1'b1;
      s.mdm_s1     <= '1;
      s.mdm_s2     <= '1;
      s.fl_s       <= 2'h3;
      s.fl_prev    <= 1'b1;
      s.txd        <= 1'b1;
      s.tst        <= SER_IDLE;
      s.rst        <= SER_IDLE;
      s.rd_n       <= 1'b1;
      s.wr_n       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Buffer storage carries no reset; pointers guard against stale reads
  always_ff @(posedge pclk) begin
    if (tx_push) begin
      tx_mem[s.tw] <= tx_in_data;
    end
    if (rx_push) begin
      rx_mem[s.rw] <= rx_push_data;
    end
  end

  // APB read mux; zero wait states
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      OFS_CTRL:  prdata = {24'h000000, s.flow, s.dtr, s.rts, s.brk,
                           s.seven, s.mode};
      OFS_BAUD:  prdata = {15'h0000, s.baud_f, s.baud_n};
      OFS_TMO:   prdata = {24'h000000, s.tmo};
      OFS_BBDIR: prdata = {24'h000000, s.bb_dir};
      OFS_MODEM: prdata = {27'h0000000, s.xoff, ~s.mdm_s2.ri_n,
                           ~s.mdm_s2.dcd_n, ~s.mdm_s2.dsr_n,
                           ~s.mdm_s2.cts_n};
      OFS_IRQST: prdata = {27'h0000000, s.irq_st};
      OFS_IRQMK: prdata = {27'h0000000, s.irq_mk};
      OFS_LEVEL: prdata = {7'h00, s.rcnt, 8'h00, s.tcnt};
      default:   pslverr = psel && penable;
    endcase
  end

  assign pready       = 1'b1;
  assign irq          = |(s.irq_st & s.irq_mk);
  assign tx_in_ready  = (s.tcnt != 8'(TX_DEPTH));
  assign rx_out_valid = (s.rcnt != 9'h000);
  assign rx_out_data  = rx_mem[s.rr];
  assign rx_release   = s.release_rx;
  assign txd          = s.txd && !s.brk;
  assign line_driver_enable = (s.tst != SER_IDLE);
  // Automatic handshake deasserts when the receive buffer nears full
  assign modem_out.rts_n = (s.flow == FLOW_RTSCTS) ?
                           (s.rcnt >= 9'(RX_HIGH)) : !s.rts;
  assign modem_out.dtr_n = (s.flow == FLOW_DTRDSR) ?
                           (s.rcnt >= 9'(RX_HIGH)) : !s.dtr;
  assign bb_out  = s.bb_out;
  assign bb_oe_n = (s.mode != USC_UART) ? ~s.bb_dir : 8'hFF;
  assign bb_rd_n = s.rd_n;
  assign bb_wr_n = s.wr_n;

endmodule : usc_channel

`default_nettype wire

// ===== usc_properties.sv
// Pin-level checker for one serial channel, bound into usc_channel.
// Assumes pclk rising edge sampling and presetn low as reset.
`timescale 1ns/1ps
`default_nettype none
module usc_chk
  import usc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  // Channel pins
  input wire logic        txd,
  input wire logic        line_driver_enable,
  input wire logic        rx_out_valid,
  input wire logic        rx_out_ready,
  input wire logic [7:0]  rx_out_data,
  input wire logic        rx_release,
  input wire logic [7:0]  bb_out,
  input wire logic        bb_wr_n,
  input wire logic        bb_rd_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shortest legal bit is above 13 cycles, so 8 is always safe
  sequence start_low;
    !txd [*8];
  endsequence
  sequence head_held;
    rx_out_valid && $stable(rx_out_data);
  endsequence
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  err_decode_a: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > OFS_LEVEL))
    else $error("address decode error flag wrong");
  rx_hold_a: assert property (rx_out_valid && !rx_out_ready |=> head_held)
    else $error("receive head byte lost while stalled");
  start_bit_a: assert property ($rose(line_driver_enable) |-> start_low)
    else $error("start bit short or driver enable early");
  frame_end_a: assert property ($fell(line_driver_enable) |-> txd)
    else $error("driver enable dropped before stop bit");
  wr_pulse_a: assert property ($fell(bb_wr_n) |=> bb_wr_n)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property ($fell(bb_rd_n) |=> bb_rd_n)
    else $error("read strobe longer than one cycle");
  out_strobe_a: assert property ($changed(bb_out) |-> !bb_wr_n)
    else $error("port output changed without write strobe");
  release_clr_a: assert property ($fell(rx_release) |-> !rx_out_valid)
    else $error("release dropped with data pending");
endmodule : usc_chk

bind usc_channel usc_chk #(.MS_CYC(MS_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .txd(txd),
  .line_driver_enable(line_driver_enable), .rx_out_valid(rx_out_valid),
  .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data),
  .rx_release(rx_release), .bb_out(bb_out), .bb_wr_n(bb_wr_n),
  .bb_rd_n(bb_rd_n)
);
`default_nettype wire

// ===== usc_peer.sv
// Serial peer on the far side of txd and rxd.
// Assumes a bit period of BIT_T pclk cycles, LSB first, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module usc_peer #(
  parameter int BIT_T = 40
) (
  // Clock and line
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  int unsigned got_cnt  = 0;
  logic [7:0]  got_byte = 8'h00;
  initial rxd = 1'h1;
  task automatic bits(input int n);
    repeat (n) @(posedge pclk);
  endtask : bits
  task automatic send_byte(input logic [7:0] b);
    rxd <= 1'h0;
    bits(BIT_T);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      bits(BIT_T);
    end
    rxd <= 1'h1;
    bits(BIT_T);
  endtask : send_byte
  // Low for longer than a frame, stop bit included
  task automatic send_break();
    rxd <= 1'h0;
    bits(12 * BIT_T);
    rxd <= 1'h1;
    bits(2 * BIT_T);
  endtask : send_break
  // Mid-bit sampling; a 7-bit frame shows its stop bit as bit 7
  initial begin : capture
    forever begin
      @(negedge txd);
      bits(BIT_T / 2);
      for (int i = 0; i < 8; i++) begin
        bits(BIT_T);
        got_byte[i] = txd;
      end
      bits(BIT_T);
      got_cnt++;
    end
  end
endmodule : usc_peer
`default_nettype wire

// ===== tb.sv
// Self-checking bench: APB tasks, byte ports, serial peer, bit-bang pins.
// Assumes the channel answers APB in its first access cycle or later.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usc_pkg::*;
  // Divisor 3.0 gives an exact bit period of 40 pclk
  localparam int BIT_T = OVERSAMPLE * CLK_MHZ * 24 / (REF_MHZ * FRAC_STEPS);
  logic           pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic           pwrite = 1'h0, pready, pslverr, irq, err, txd, rxd;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0, prdata, rd;
  logic           tx_in_valid = 1'h0, tx_in_ready, rx_out_valid;
  logic           rx_out_ready = 1'h0, rx_release, line_driver_enable;
  logic [7:0]     tx_in_data = 8'h00, rx_out_data, bb_in = 8'h00;
  logic [7:0]     bb_out, bb_oe_n;
  logic           bb_rd_n, bb_wr_n, flush_or_wakeup_n = 1'h1;
  logic           cfg_present = 1'h0, cfg_parallel = 1'h0;
  usc_modem_in_t  modem_in = 4'hF;
  usc_modem_out_t modem_out;
  int             bad_count = 0, checks_done = 0, cycles = 0, n;

  usc_channel #(.MS_CYC(40)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_in_ready(tx_in_ready), .rx_out_valid(rx_out_valid),
    .rx_out_data(rx_out_data), .rx_out_ready(rx_out_ready),
    .rx_release(rx_release), .cfg_present(cfg_present),
    .cfg_parallel(cfg_parallel),
    .txd(txd), .rxd(rxd), .modem_in(modem_in), .modem_out(modem_out),
    .line_driver_enable(line_driver_enable),
    .flush_or_wakeup_n(flush_or_wakeup_n), .bb_in(bb_in),
    .bb_out(bb_out), .bb_oe_n(bb_oe_n), .bb_rd_n(bb_rd_n),
    .bb_wr_n(bb_wr_n)
  );
  usc_peer #(.BIT_T(BIT_T)) peer (.pclk(pclk), .txd(txd), .rxd(rxd));

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rd_chk
  task automatic push(input logic [7:0] b);
    @(posedge pclk);
    tx_in_valid <= 1'h1;
    tx_in_data <= b;
    @(posedge pclk);
    while (tx_in_ready !== 1'h1) @(posedge pclk);
    tx_in_valid <= 1'h0;
  endtask : push
  task automatic pop();
    @(posedge pclk);
    rx_out_ready <= 1'h1;
    @(posedge pclk);
    rx_out_ready <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask : pop
  task automatic peer_byte(input logic [7:0] e);
    int c0;
    c0 = peer.got_cnt;
    for (n = 0; n < 3000 && peer.got_cnt == c0; n++) @(posedge pclk);
    chk(32'(peer.got_cnt - c0), 32'h1);
    chk(peer.got_byte, e);
  endtask : peer_byte

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_BAUD, 32'h00010138);
    rd_chk(OFS_TMO, 32'h10);
    apb(1'h0, 12'h020, 32'h0);
    chk(err, 1'h1);
    apb(1'h1, OFS_BAUD, 32'h3);
    apb(1'h1, OFS_TMO, 32'h2);
    push(8'hA5);
    peer_byte(8'hA5);
    apb(1'h1, OFS_CTRL, 32'h4);
    push(8'h43);
    peer_byte(8'hC3);
    apb(1'h1, OFS_CTRL, 32'h0);
    peer.send_byte(8'h5A);
    chk(rx_out_data, 8'h5A);
    chk(rx_release, 1'h0);
    chk(irq, 1'h0);
    apb(1'h1, OFS_IRQMK, 32'h1);
    @(posedge pclk);
    chk(irq, 1'h1);
    apb(1'h1, OFS_IRQST, 32'h1);
    @(posedge pclk);
    chk(irq, 1'h0);
    for (n = 0; n < 300 && rx_release !== 1'h1; n++) @(posedge pclk);
    chk(rx_release, 1'h1);
    rd_chk(OFS_IRQST, 32'h4);
    pop();
    chk(rx_release, 1'h0);
    apb(1'h1, OFS_IRQST, 32'h1F);
    peer.send_break();
    rd_chk(OFS_IRQST, 32'h2);
    chk(rx_out_valid, 1'h0);
    apb(1'h1, OFS_CTRL, 32'h8);
    repeat (2) @(posedge pclk);
    chk(txd, 1'h0);
    apb(1'h1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk(txd, 1'h1);
    repeat (10 * BIT_T) @(posedge pclk);
    apb(1'h1, OFS_TMO, 32'hFF);
    apb(1'h1, OFS_IRQST, 32'h1F);
    peer.send_byte(8'h81);
    flush_or_wakeup_n <= 1'h0;
    repeat (3) @(posedge pclk);
    flush_or_wakeup_n <= 1'h1;
    repeat (4) @(posedge pclk);
    chk(rx_release, 1'h1);
    rd_chk(OFS_IRQST, 32'h9);
    pop();
    modem_in <= 4'h2;
    repeat (4) @(posedge pclk);
    rd_chk(OFS_MODEM, 32'hB);
    apb(1'h1, OFS_CTRL, 32'h30);
    @(posedge pclk);
    chk(modem_out, 2'h0);
    modem_in <= 4'hA;
    apb(1'h1, OFS_CTRL, 32'h40);
    @(posedge pclk);
    chk(modem_out, 2'h1);
    push(8'h0F);
    repeat (5 * BIT_T) @(posedge pclk);
    chk(line_driver_enable, 1'h0);
    modem_in <= 4'h2;
    peer_byte(8'h0F);
    apb(1'h1, OFS_CTRL, 32'hC0);
    peer.send_byte(XOFF_CHAR);
    rd_chk(OFS_MODEM, 32'h1B);
    push(8'h24);
    repeat (5 * BIT_T) @(posedge pclk);
    chk(line_driver_enable, 1'h0);
    peer.send_byte(XON_CHAR);
    peer_byte(8'h24);
    bb_in <= 8'h96;
    apb(1'h1, OFS_BBDIR, 32'hFF);
    apb(1'h1, OFS_CTRL, 32'h1);
    @(posedge pclk);
    chk(bb_oe_n, 8'h00);
    push(8'h3C);
    for (n = 0; n < 200 && bb_wr_n !== 1'h0; n++) @(posedge pclk);
    chk(bb_out, 8'h3C);
    for (n = 0; n < 200 && bb_rd_n !== 1'h0; n++) @(posedge pclk);
    chk(rx_out_data, 8'h96);
    apb(1'h1, OFS_CTRL, 32'h2);
    repeat (2 * BIT_T) @(posedge pclk);
    rx_out_ready <= 1'h1;
    for (n = 0; n < 600 && rx_out_valid === 1'h1; n++) @(posedge pclk);
    rx_out_ready <= 1'h0;
    repeat (4 * BIT_T) @(posedge pclk);
    chk(rx_out_valid, 1'h0);
    bb_in <= 8'h69;
    push(8'h55);
    repeat (4 * BIT_T) @(posedge pclk);
    chk(bb_out, 8'h55);
    chk(rx_out_data, 8'h69);
    rd_chk(OFS_LEVEL, 32'h00010000);
    cfg_present <= 1'h1;
    cfg_parallel <= 1'h1;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(rx_out_valid, 1'h0);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    rd_chk(OFS_CTRL, 32'h1);
    results();
  end
endmodule : tb
`default_nettype wire
